// ==== rtl/ddc_top.sv ====
// Drive-side command decoder and status logic for the control cable.
// Assumes cable inputs are asynchronous; WRITE_CLOCK comes from the CU.
`timescale 1ns/1ps
module ddc_top
   import ddc_pkg::*;
#(
   parameter int MAX_CYL   = 822,
   parameter int SEEK_US   = 5000,
   parameter int OFF_US    = 2000,
   parameter int REV_US    = 16667,
   parameter int SECTORS   = 32,
   parameter int RD_HALF   = 2
) (
   // Clocks and reset
   input  wire logic              SYS_CLK,
   input  wire logic              RESET_N,
   input  wire logic              WRITE_CLOCK,
   // Control cable from the CU
   input  wire logic              TAG_SET_CYL,
   input  wire logic              TAG_HEAD_SET,
   input  wire logic              TAG_CTRL_SEL,
   input  wire logic [BUS_W-1:0]  BUS_IN,
   // Drive internals in
   input  wire logic              MAINT_MODE,
   input  wire logic              WP_SWITCH,
   input  wire logic              DRIVE_READY_IN,
   input  wire logic              FAULT_COND,
   input  wire logic              SEEK_FAIL,
   input  wire logic              MEDIA_RD_BIT,
   input  wire logic              AM_DETECT,
   // Status to the CU
   output logic                   INDEX_MARK,
   output logic                   SECTOR_MARK,
   output logic                   FAULT,
   output logic                   SEEK_ERROR,
   output logic                   ON_CYL,
   output logic                   UNIT_READY,
   output logic                   WRITE_PROT,
   output logic                   ADDR_MARK,
   output logic                   SEEK_END,
   // Serial link
   input  wire logic              WRITE_DATA,
   output logic                   READ_DATA,
   output logic                   READ_CLOCK,
   // Drive internals out
   output logic                   WR_ENABLE,
   output logic                   AM_WRITE,
   output logic                   RD_ENABLE,
   output logic                   AM_SEARCH,
   output logic                   OFFSET_FWD,
   output logic                   OFFSET_REV,
   output logic                   STROBE_EARLY,
   output logic                   STROBE_LATE,
   output logic [BUS_W-1:0]       CYL_ADDR,
   output logic [HEAD_W-1:0]      HEAD_ADDR,
   output logic [BYTE_W-1:0]      WR_BYTE,
   output logic                   WR_BYTE_STB
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int SYN_W = BUS_W + 10;
   logic [SYN_W-1:0] syn;
   logic             sc_a, hs_a, cs_a, maint_s, wp_s, drdy_s;
   logic             fcond_s, sfail_s, mbit_s, amdet_s;
   logic [BUS_W-1:0] bus_s;

   ddc_sync #(.W(SYN_W)) u_sync (
      .clk   (SYS_CLK),
      .rst_n (RESET_N),
      .d     ({TAG_SET_CYL, TAG_HEAD_SET, TAG_CTRL_SEL, BUS_IN,
               MAINT_MODE, WP_SWITCH, DRIVE_READY_IN, FAULT_COND,
               SEEK_FAIL, MEDIA_RD_BIT, AM_DETECT}),
      .q     (syn)
   );
   assign {sc_a, hs_a, cs_a, bus_s, maint_s, wp_s, drdy_s,
           fcond_s, sfail_s, mbit_s, amdet_s} = syn;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   logic             sc_s, hs_s, off_s;
   logic [BUS_W-1:0] cmd;
   logic             sc_d_r, hs_d_r, off_d_r, rz_d_r, sf_d_r;
   logic             sc_rise, sc_fall, hs_rise, off_rise, off_fall;
   logic             rz_rise, sf_rise, wg, fault_cause;

   assign sc_s     = sc_a & !maint_s;
   assign hs_s     = hs_a & !maint_s;
   assign cmd      = (cs_a && !maint_s) ? bus_s : '0;
   assign wg       = cmd[BL_WG];
   assign off_s    = cmd[BL_OFF_F] | cmd[BL_OFF_R];
   assign sc_rise  = sc_s & !sc_d_r;
   assign sc_fall  = !sc_s & sc_d_r;
   assign hs_rise  = hs_s & !hs_d_r;
   assign off_rise = off_s & !off_d_r;
   assign off_fall = !off_s & off_d_r;
   assign rz_rise  = cmd[BL_RZ] & !rz_d_r;
   assign sf_rise  = sfail_s & !sf_d_r;
   assign fault_cause = fcond_s | (wg & wp_s) | (wg & off_s);

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sc_d_r  <= 1'b0;
         hs_d_r  <= 1'b0;
         off_d_r <= 1'b0;
         rz_d_r  <= 1'b0;
         sf_d_r  <= 1'b0;
      end else begin
         sc_d_r  <= sc_s;
         hs_d_r  <= hs_s;
         off_d_r <= off_s;
         rz_d_r  <= cmd[BL_RZ];
         sf_d_r  <= sfail_s;
      end
   end

   // ----------------------------------------------------------------
   // Positioner and status state
   // ----------------------------------------------------------------
   ddc_pos_t          pos_r, pos_nxt;
   logic [TMR_W-1:0]  tmr_r, tmr_nxt;
   logic [BUS_W-1:0]  cyl_r, cyl_nxt, pend_r, pend_nxt;
   logic [HEAD_W-1:0] head_r, head_nxt;
   logic fault_r, fault_nxt, err_r, err_nxt, oc_r, oc_nxt;
   logic se_r, se_nxt, rdy_nxt;
   logic us_tick, idx_w, sec_w;

   always_comb begin
      fault_nxt = fault_cause | (fault_r & !cmd[BL_FRST]);
      rdy_nxt   = drdy_s & !fault_nxt;
      pos_nxt   = pos_r;
      tmr_nxt   = tmr_r;
      cyl_nxt   = cyl_r;
      pend_nxt  = pend_r;
      head_nxt  = head_r;
      err_nxt   = err_r;
      oc_nxt    = oc_r;
      se_nxt    = se_r;
      case (pos_r)
         POS_MOVE: begin
            if (us_tick) begin
               if (tmr_r == '0) begin
                  pos_nxt = POS_IDLE;
                  oc_nxt  = !err_r;
               end else begin
                  tmr_nxt = tmr_r - 1'b1;
               end
            end
         end
         default: ;
      endcase
      if (sc_rise) begin
         pend_nxt = bus_s;
         if (bus_s > BUS_W'(MAX_CYL)) err_nxt = 1'b1;
      end
      if (sc_fall) begin
         oc_nxt = 1'b0;
         se_nxt = 1'b0;
         if (!err_nxt) begin
            cyl_nxt = pend_r;
            pos_nxt = POS_MOVE;
            tmr_nxt = TMR_W'(SEEK_US);
         end
      end
      if (off_rise) begin
         oc_nxt  = 1'b0;
         se_nxt  = 1'b0;
         pos_nxt = POS_MOVE;
         tmr_nxt = TMR_W'(OFF_US);
      end
      if (off_fall) begin
         pos_nxt = POS_MOVE;
         tmr_nxt = TMR_W'(OFF_US);
      end
      if (rz_rise) begin
         oc_nxt   = 1'b0;
         se_nxt   = 1'b0;
         err_nxt  = 1'b0;
         head_nxt = HEAD_ZERO;
         cyl_nxt  = CYL_ZERO;
         pos_nxt  = POS_MOVE;
         tmr_nxt  = TMR_W'(SEEK_US);
      end
      if (hs_rise) head_nxt = bus_s[HEAD_W-1:0];
      if (sf_rise) err_nxt = 1'b1;
      if ((oc_nxt & !oc_r) | (err_nxt & !err_r)) se_nxt = 1'b1;
      if (sc_s | !rdy_nxt) se_nxt = 1'b0;
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pos_r   <= POS_IDLE;
         tmr_r   <= '0;
         cyl_r   <= '0;
         pend_r  <= '0;
         head_r  <= '0;
         fault_r <= 1'b0;
         err_r   <= 1'b0;
         oc_r    <= 1'b0;
         se_r    <= 1'b0;
      end else begin
         pos_r   <= pos_nxt;
         tmr_r   <= tmr_nxt;
         cyl_r   <= cyl_nxt;
         pend_r  <= pend_nxt;
         head_r  <= head_nxt;
         fault_r <= fault_nxt;
         err_r   <= err_nxt;
         oc_r    <= oc_nxt;
         se_r    <= se_nxt;
      end
   end

   ddc_rot #(.REV_US(REV_US), .SECTORS(SECTORS)) u_rot (
      .SYS_CLK  (SYS_CLK),
      .RESET_N  (RESET_N),
      .us_tick  (us_tick),
      .index_r  (idx_w),
      .sector_r (sec_w)
   );

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   logic wr_en, rd_en, am_hit;
   // fault blocks transfer
   // Coming fault gates too, so a protected write never opens a cycle
   // write gate
   assign wr_en  = wg & !fault_r & !fault_nxt;
   assign rd_en  = cmd[BL_RG] & !fault_r & !fault_nxt;
   assign am_hit = rd_en & cmd[BL_AME] & amdet_s;

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         {INDEX_MARK, SECTOR_MARK, FAULT, SEEK_ERROR, ON_CYL} <= '0;
         {UNIT_READY, WRITE_PROT, ADDR_MARK, SEEK_END}       <= '0;
         {WR_ENABLE, AM_WRITE, RD_ENABLE, AM_SEARCH}         <= '0;
         {OFFSET_FWD, OFFSET_REV, STROBE_EARLY, STROBE_LATE} <= '0;
         CYL_ADDR  <= '0;
         HEAD_ADDR <= '0;
      end else begin
         INDEX_MARK  <= idx_w & !maint_s;
         SECTOR_MARK <= sec_w & !maint_s;
         FAULT       <= fault_r & !maint_s;
         SEEK_ERROR  <= err_r & !maint_s;
         ON_CYL      <= oc_r & !maint_s;
         UNIT_READY  <= drdy_s & !fault_r & !maint_s;
         WRITE_PROT  <= wp_s & !maint_s;
         ADDR_MARK   <= am_hit;
         SEEK_END    <= se_r & !maint_s;
         WR_ENABLE   <= wr_en;
         AM_WRITE    <= wr_en & cmd[BL_AME];
         RD_ENABLE   <= rd_en;
         AM_SEARCH   <= rd_en & cmd[BL_AME];
         OFFSET_FWD  <= cmd[BL_OFF_F];
         OFFSET_REV  <= cmd[BL_OFF_R];
         STROBE_EARLY <= cmd[BL_STE];
         STROBE_LATE  <= cmd[BL_STL];
         CYL_ADDR    <= cyl_r;
         HEAD_ADDR   <= head_r;
      end
   end

   // ----------------------------------------------------------------
   // Read clock and data
   // ----------------------------------------------------------------
   logic [7:0] rc_r, rc_nxt;
   logic       rclk_nxt, rdat_nxt;

   always_comb begin
      rc_nxt   = (rc_r == 8'(RD_HALF - 1)) ? '0 : rc_r + 8'h01;
      rclk_nxt = READ_CLOCK;
      rdat_nxt = READ_DATA;
      if (rc_r == 8'(RD_HALF - 1)) begin
         rclk_nxt = !READ_CLOCK;
         if (READ_CLOCK) rdat_nxt = RD_ENABLE & mbit_s;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rc_r       <= '0;
         READ_CLOCK <= 1'b0;
         READ_DATA  <= 1'b0;
      end else begin
         rc_r       <= rc_nxt;
         READ_CLOCK <= rclk_nxt;
         READ_DATA  <= rdat_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Write link domain
   // ----------------------------------------------------------------
   // Byte hold stays stable eight link clocks, well past the toggle sync
   logic              wen_l, tgl_l_r, tgl_l_nxt, tgl_s, tgl_d_r;
   logic [2:0]        bc_r, bc_nxt;
   logic [BYTE_W-1:0] sh_r, sh_nxt, hold_r, hold_nxt;

   ddc_sync #(.W(1)) u_wen (
      .clk (WRITE_CLOCK), .rst_n (RESET_N), .d (WR_ENABLE), .q (wen_l));

   always_comb begin
      sh_nxt    = {sh_r[BYTE_W-2:0], WRITE_DATA};
      bc_nxt    = wen_l ? bc_r + 3'h1 : '0;
      hold_nxt  = hold_r;
      tgl_l_nxt = tgl_l_r;
      if (wen_l && bc_r == 3'h7) begin
         hold_nxt  = sh_nxt;
         tgl_l_nxt = !tgl_l_r;
      end
   end

   always_ff @(posedge WRITE_CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         sh_r    <= '0;
         bc_r    <= '0;
         hold_r  <= '0;
         tgl_l_r <= 1'b0;
      end else begin
         sh_r    <= sh_nxt;
         bc_r    <= bc_nxt;
         hold_r  <= hold_nxt;
         tgl_l_r <= tgl_l_nxt;
      end
   end

   ddc_sync #(.W(1)) u_tgl (
      .clk (SYS_CLK), .rst_n (RESET_N), .d (tgl_l_r), .q (tgl_s));

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tgl_d_r     <= 1'b0;
         WR_BYTE     <= '0;
         WR_BYTE_STB <= 1'b0;
      end else begin
         tgl_d_r     <= tgl_s;
         WR_BYTE_STB <= tgl_s ^ tgl_d_r;
         if (tgl_s ^ tgl_d_r) WR_BYTE <= hold_r;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_MAINT_QUIET: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      maint_s |=> !(FAULT | SEEK_ERROR | ON_CYL | UNIT_READY
                    | WRITE_PROT | ADDR_MARK | SEEK_END | INDEX_MARK
                    | SECTOR_MARK))
      else $error("Status active in maintenance mode");
   AST_WP_FAULT: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      wg && wp_s |=> fault_r ##1 (FAULT || $past(maint_s)))
      else $error("Write on protected disk gave no fault");
   AST_OFF_WG_FAULT: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      wg && off_s |=> fault_r)
      else $error("Offset during write gave no fault");
   AST_FAULT_BLOCK: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      fault_r |=> !WR_ENABLE && !RD_ENABLE && !UNIT_READY)
      else $error("Fault did not block transfer");
   AST_FAULT_HOLD: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      fault_r && fcond_s |=> fault_r)
      else $error("Fault cleared while cause remains");
   AST_RZ_CLEAR: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      rz_rise && !sf_rise |=> !oc_r && !se_r && !err_r
                              && head_r == HEAD_ZERO)
      else $error("Rezero did not clear status");
   AST_SC_TRAIL: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      sc_fall |=> !oc_r && !se_r)
      else $error("Set-cylinder trail kept on-cylinder");
   AST_SEEK_END: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      $rose(oc_r) && !$past(sc_s) && $past(rdy_nxt) |-> se_r)
      else $error("Seek end missing after on-cylinder");
   AST_AM_FOUND: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      ADDR_MARK |-> $past(rd_en) && $past(cmd[BL_AME]))
      else $error("Address mark without read and enable");
   AST_WR_BYTE: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      WR_BYTE_STB |=> !WR_BYTE_STB)
      else $error("Write byte strobe longer than one cycle");

   COV_REZERO: cover property (
      @(posedge SYS_CLK) disable iff (!RESET_N) rz_rise ##[1:1000] oc_r);
   COV_OFFSET: cover property (
      @(posedge SYS_CLK) disable iff (!RESET_N) off_rise);
   COV_BYTE: cover property (
      @(posedge SYS_CLK) disable iff (!RESET_N) WR_BYTE_STB);
   COV_FRST: cover property (
      @(posedge SYS_CLK) disable iff (!RESET_N) $fell(fault_r));
endmodule : ddc_top

// ==== common/ddc_pkg.sv ====
// Constants for the drive-side control-select decoder and status logic.
// Assumes a 25 MHz system clock; all times are converted here.
package ddc_pkg;
   // ----------------------------------------------------------------
   // Clock and time base
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int US_NS         = 1000;
   localparam int US_CYC        = US_NS / CLK_PERIOD_NS;
   localparam int IDX_MIN_NS    = 2000;
   localparam int SEC_MIN_NS    = 1000;
   localparam int PULSE_MAX_NS  = 5000;
   // Least times round up, longest time rounds down
   localparam int IDX_MIN_CYC   =
      (IDX_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SEC_MIN_CYC   =
      (SEC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_PERIOD_NS;
   // Generated pulse widths in microseconds, inside the limits above
   localparam int IDX_W_US      = 3;
   localparam int SEC_W_US      = 2;
   // ----------------------------------------------------------------
   // Bus line positions under control select
   // ----------------------------------------------------------------
   localparam int BUS_W         = 10;
   localparam int BL_WG         = 0;
   localparam int BL_RG         = 1;
   localparam int BL_OFF_F      = 2;
   localparam int BL_OFF_R      = 3;
   localparam int BL_FRST       = 4;
   localparam int BL_AME        = 5;
   localparam int BL_RZ         = 6;
   localparam int BL_STE        = 7;
   localparam int BL_STL        = 8;
   localparam int HEAD_W        = 7;
   localparam int TMR_W         = 16;
   localparam int BYTE_W        = 8;
   localparam logic [BUS_W-1:0] CYL_ZERO  = 10'h000;
   localparam logic [HEAD_W-1:0] HEAD_ZERO = 7'h00;
   // ----------------------------------------------------------------
   // Positioner states
   // ----------------------------------------------------------------
   typedef enum logic {POS_IDLE, POS_MOVE} ddc_pos_t;
endpackage : ddc_pkg

// ==== rtl/ddc_sync.sv ====
// Two flip-flop synchroniser for a vector of levels.
// Assumes each bit is a slow level; bits may land one cycle apart.
`timescale 1ns/1ps
module ddc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // First stage feeds the second stage only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : ddc_sync

// ==== rtl/ddc_rot.sv ====
// Rotational reference: microsecond tick, index and sector pulses.
// Assumes the disk turns at a fixed rate set by parameters.
`timescale 1ns/1ps
module ddc_rot
   import ddc_pkg::*;
#(
   parameter int REV_US  = 16667,
   parameter int SECTORS = 32
) (
   // Clock and reset
   input  wire logic SYS_CLK,
   input  wire logic RESET_N,
   // Timing outputs
   output logic      us_tick,
   output logic      index_r,
   output logic      sector_r
);
   localparam int SEC_LEN_US = REV_US / SECTORS;

   logic [7:0]  pre_r,  pre_nxt;
   logic [TMR_W-1:0] spos_r, spos_nxt;
   logic [7:0]  snum_r, snum_nxt;
   logic        idx_nxt, sec_nxt;
   logic [7:0]  wcnt_r;

   assign us_tick = (pre_r == 8'(US_CYC - 1));

   always_comb begin
      pre_nxt  = us_tick ? '0 : pre_r + 8'h01;
      spos_nxt = spos_r;
      snum_nxt = snum_r;
      if (us_tick) begin
         if (spos_r == TMR_W'(SEC_LEN_US - 1)) begin
            spos_nxt = '0;
            snum_nxt = (snum_r == 8'(SECTORS - 1)) ? '0 : snum_r + 8'h01;
         end else begin
            spos_nxt = spos_r + 1'b1;
         end
      end
      idx_nxt = (snum_r == '0) && (spos_r < TMR_W'(IDX_W_US));
      sec_nxt = (snum_r != '0) && (spos_r < TMR_W'(SEC_W_US)) && !idx_nxt;
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pre_r    <= '0;
         spos_r   <= '0;
         snum_r   <= '0;
         index_r  <= 1'b0;
         sector_r <= 1'b0;
      end else begin
         pre_r    <= pre_nxt;
         spos_r   <= spos_nxt;
         snum_r   <= snum_nxt;
         index_r  <= idx_nxt;
         sector_r <= sec_nxt;
      end
   end

   // Width counter, read only by the checks below
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wcnt_r <= '0;
      end else if (index_r || sector_r) begin
         wcnt_r <= wcnt_r + 8'h01;
      end else begin
         wcnt_r <= '0;
      end
   end

   AST_IDX_WIDTH: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      $fell(index_r) |-> (wcnt_r >= 8'(IDX_MIN_CYC))
                         && (wcnt_r <= 8'(PULSE_MAX_CYC)))
      else $error("Index pulse width out of range");
   AST_SEC_WIDTH: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      $fell(sector_r) |-> (wcnt_r >= 8'(SEC_MIN_CYC))
                          && (wcnt_r <= 8'(PULSE_MAX_CYC)))
      else $error("Sector pulse width out of range");
   AST_NO_SEC_AT_IDX: assert property (
      @(posedge SYS_CLK) disable iff (!RESET_N)
      index_r |-> !sector_r)
      else $error("Sector pulse during index");
   COV_INDEX: cover property (
      @(posedge SYS_CLK) disable iff (!RESET_N) $rose(index_r));
endmodule : ddc_rot

// ==== sim/ddc_cu.sv ====
// CU model: write clock and data, read data capture.
// Assumes the drive runs its read clock freely.
`timescale 1ns/1ps
module ddc_cu (
   // Link
   input  wire logic run,
   input  wire logic rclk,
   input  wire logic rdat,
   output logic      wclk,
   output logic      wdat,
   output logic      rbit
);
   // ----
   // Link
   // ----
   // clock runs only in frames
   initial begin
      wclk = 1'b0;
      #7;
      forever #32 wclk = run ? ~wclk : 1'b0;
   end
   // data moves off the sampling edge
   always @(negedge wclk) wdat <= run;
   always @(posedge rclk) rbit <= rdat;
endmodule : ddc_cu

// ==== sim/ddc_top_tb.sv ====
// Bench for the control-select decoder and status logic.
// Assumes the CU model ddc_cu on the link.
`timescale 1ns/1ps
`define CK(a,b) begin checks++; if ((a)!==(b)) begin n_fail++; \
 $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module ddc_top_tb;
   import ddc_pkg::*;
   // ----
   // Bench
   // ----
   logic clk = 0, rst_n = 0, sc = 0, hs = 0, cs = 0, mm = 0, wp = 0;
   logic fc = 0, sf = 0, mb = 0, amd = 0, run = 0, rdy = 1;
   logic [9:0] bus = 0;
   logic [7:0] got = 0;
   logic im, sm, flt, se, oc, ur, am, send, rd, rc, wen, rde, ams, ofw;
   logic wc, wd, rb, wbs, wpo, amw, orv, ste, stl, im_d = 0, sm_d = 0;
   logic [9:0] cyl;
   logic [7:0] wb;
   logic [6:0] hd;
   int n_fail = 0, checks = 0, cyc = 0, n_idx = 0, n_sec = 0;
   initial forever #20 clk = ~clk;
   ddc_top #(.SEEK_US(5), .OFF_US(5), .REV_US(40), .SECTORS(4))
   ddc_top_inst (.SYS_CLK(clk), .RESET_N(rst_n), .WRITE_CLOCK(wc),
      .TAG_SET_CYL(sc), .TAG_HEAD_SET(hs), .TAG_CTRL_SEL(cs),
      .BUS_IN(bus), .MAINT_MODE(mm), .WP_SWITCH(wp),
      .DRIVE_READY_IN(rdy), .FAULT_COND(fc), .SEEK_FAIL(sf),
      .MEDIA_RD_BIT(mb), .AM_DETECT(amd), .INDEX_MARK(im),
      .SECTOR_MARK(sm), .FAULT(flt), .SEEK_ERROR(se), .ON_CYL(oc),
      .UNIT_READY(ur), .WRITE_PROT(wpo), .ADDR_MARK(am), .SEEK_END(send),
      .WRITE_DATA(wd), .READ_DATA(rd), .READ_CLOCK(rc), .WR_ENABLE(wen),
      .AM_WRITE(amw), .RD_ENABLE(rde), .AM_SEARCH(ams), .OFFSET_FWD(ofw),
      .OFFSET_REV(orv), .STROBE_EARLY(ste), .STROBE_LATE(stl),
      .CYL_ADDR(cyl), .HEAD_ADDR(hd), .WR_BYTE(wb), .WR_BYTE_STB(wbs));
   ddc_cu ddc_cu_inst (.run(run), .rclk(rc), .rdat(rd), .wclk(wc),
      .wdat(wd), .rbit(rb));
   always @(posedge clk) if (wbs === 1'b1) got <= wb;
   // Rising edges of index and sector, counted per window
   always @(posedge clk) begin
      im_d <= im;
      sm_d <= sm;
      if (im === 1'b1 && im_d === 1'b0) n_idx++;
      if (sm === 1'b1 && sm_d === 1'b0) n_sec++;
   end
   task close_out;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   // Tags {set cyl, head set, ctrl sel}, held n cycles
   task cmd(input logic [2:0] t, input logic [9:0] b, input int n);
      {sc, hs, cs} = t;
      bus = b;
      repeat (n) @(posedge clk);
      #2;
   endtask : cmd
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         close_out;
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      #2 rst_n = 1;
      cmd(0, 0, 25);
      cmd(2, 10'h02A, 8);
      `CK(hd, 7'h2A)
      cmd(1, 10'h040, 8);
      `CK({oc, hd}, 8'h00)
      cmd(0, 0, 200);
      `CK({oc, send, se, cyl}, 13'h1800)
      cmd(4, 10'h3FF, 8);
      `CK({se, send}, 2'b10)
      cmd(1, 10'h040, 8);
      `CK(se, 1'b0)
      cmd(4, 10'h005, 200);
      `CK(oc, 1'b1)
      cmd(0, 0, 8);
      `CK({oc, send}, 2'b00)
      cmd(0, 0, 200);
      `CK({oc, cyl}, 11'h405)
      $display("test seek done");
      cmd(1, 10'h004, 8);
      `CK({ofw, oc, send}, 3'b100)
      cmd(1, 10'h004, 200);
      cmd(0, 0, 8);
      `CK(oc, 1'b1)
      // Settle wait after offset removal
      cmd(0, 0, 300);
      wp = 1;
      cmd(1, 10'h001, 8);
      `CK({flt, ur, wen, wpo}, 4'h9)
      {wp, fc} = 2'b01;
      cmd(1, 10'h010, 8);
      `CK(flt, 1'b1)
      fc = 0;
      cmd(1, 10'h010, 8);
      `CK({flt, ur}, 2'b01)
      cmd(1, 10'h005, 8);
      `CK({flt, ur}, 2'b10)
      cmd(1, 10'h010, 300);
      `CK(flt, 1'b0)
      $display("test fault done");
      {mb, amd} = 2'b11;
      cmd(1, 10'h0AA, 12);
      `CK({rde, ams, am, rb, orv, ste}, 6'h3F)
      mb = 0;
      cmd(1, 10'h122, 12);
      `CK({rb, stl, ste, orv}, 4'h4)
      amd = 0;
      run = 1;
      cmd(0, 0, 8);
      cmd(1, 10'h021, 40);
      `CK({wen, amw, got}, 10'h3FF)
      cmd(0, 0, 8);
      run = 0;
      $display("test link done");
      // One full turn, long after status became valid
      n_idx = 0;
      n_sec = 0;
      cmd(0, 0, 1000);
      `CK(n_idx, 1)
      `CK(n_sec, 3)
      $display("test rotation done");
      mm = 1;
      cmd(1, 10'h040, 8);
      `CK({oc, send, ur, flt}, 4'h0)
      mm = 0;
      cmd(0, 0, 8);
      `CK(oc, 1'b1)
      $display("test maint done");
      close_out;
   end
endmodule : ddc_top_tb
